// ### rtl/acc_consts.svh
// constants shared by both ends of the accelerometer register port link
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ---------------------------------------------------------------
// addressing and framing
// ---------------------------------------------------------------
`define ACC_SLAVE_ADDR   7'h1d
`define ACC_DIR_READ     1'b1
`define ACC_DIR_WRITE    1'b0
`define ACC_LAST_BIT     4'h7
`define ACC_ACK_BIT      4'h8
`define ACC_FIRST_BIT    4'h1
`define ACC_BIT_ZERO     4'h0
`define ACC_BYTE_ZERO    8'h00
`define ACC_BYTE_ONE     8'h01

// ---------------------------------------------------------------
// timing: bit rates and the quarter bit derived from the clock
// ---------------------------------------------------------------
`define ACC_CLK_HZ       25000000
`define ACC_STD_BPS      100000
`define ACC_FAST_BPS     400000
`define ACC_QTR_CYC(bps) ((`ACC_CLK_HZ + 4 * (bps) - 1) / (4 * (bps)))

`endif

// ### rtl/acc_pkg.sv
// types shared by both ends of the accelerometer register port link
package acc_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ADDR,
        DEV_REG,
        DEV_WR,
        DEV_RD
    } acc_dev_state_type;

    typedef enum logic [1:0] {
        HST_IDLE,
        HST_START,
        HST_BIT,
        HST_STOP
    } acc_hst_state_type;

    typedef enum logic [2:0] {
        SEG_ADW,
        SEG_REG,
        SEG_ADR,
        SEG_RD,
        SEG_WR
    } acc_hst_seg_type;

endpackage : acc_pkg

// ### rtl/acc_i2c_if.sv
// two-wire bus between the register port master and the accelerometer slave
`timescale 1ns/1ps

interface acc_i2c_if;
    logic host_scl_oe;
    logic host_sda_oe;
    logic dev_scl_oe;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // open-drain wiring: pull-ups give the high level, any enable pulls low
    assign scl = ~(host_scl_oe | dev_scl_oe);
    assign sda = ~(host_sda_oe | dev_sda_oe);

    modport host (
        output host_scl_oe,
        output host_sda_oe,
        input  scl,
        input  sda
    );

    modport dev (
        output dev_scl_oe,
        output dev_sda_oe,
        input  scl,
        input  sda
    );
endinterface : acc_i2c_if

// ### rtl/acc_i2c_dev.sv
// accelerometer end: two-wire slave register port clocked by the bus clock
`timescale 1ns/1ps
`include "acc_consts.svh"

// Summary of operation
// - device is only a slave, never master
// - device never holds the clock low
// - standard mode up to 100 kbit/s
// - fast mode up to 400 kbit/s
// - eight-bit bytes, each followed by acknowledge
// - answer only fixed address 1d, pin ignored
// - lines only pulled low or released
// - data sampled only while clock high
// - data changes while clock low; edges mark start/stop; device decodes only start, a stop is ignored
// - both lines released when bus idle
// - direction bit one reads, zero writes
// - read: register address, repeated start, data, nak
// - write: register address, data bytes, stop
module acc_i2c_dev #(
    parameter int DEPTH = 32
) (
    acc_i2c_if.dev           bus,
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        slave_address_select_pin_in,
    output logic             wr_stb_out,
    output logic [7:0]       wr_addr_out,
    output logic [7:0]       wr_data_out,
    output logic             rd_stb_out,
    output logic [7:0]       rd_addr_out,
    output logic             selected_out
);
    import acc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // ---------------------------------------------------------------
    // start detection on the falling data edge
    // ---------------------------------------------------------------
    // a data edge while the clock is high is only legal as start or stop,
    // so the toggle is stable for half a bus clock before it is read
    logic start_tog_reg;

    always_ff @(negedge bus.sda or negedge resetn_in) begin
        if (!resetn_in) begin
            start_tog_reg <= 1'b0;
        end else if (bus.scl) begin
            start_tog_reg <= ~start_tog_reg;
        end
    end

    // ---------------------------------------------------------------
    // link state on the bus clock
    // ---------------------------------------------------------------
    acc_dev_state_type state_reg;
    acc_dev_state_type state_next;
    acc_dev_state_type go_reg;
    acc_dev_state_type go_next;
    logic [3:0]        bit_reg;
    logic [3:0]        bit_next;
    logic [7:0]        shift_reg;
    logic [7:0]        shift_next;
    logic [7:0]        tx_reg;
    logic [7:0]        tx_next;
    logic [7:0]        ptr_reg;
    logic [7:0]        ptr_next;
    logic              ack_reg;
    logic              ack_next;
    logic              seen_reg;
    logic              seen_next;
    logic [1:0]        evt_tog_reg;
    logic [1:0]        evt_tog_next;
    logic [7:0]        wr_addr_reg;
    logic [7:0]        wr_data_reg;
    logic [7:0]        rd_addr_reg;
    logic              mem_we;
    logic              sda_low_reg;
    logic [7:0]        mem [DEPTH];

    wire       start_pend = start_tog_reg ^ seen_reg;
    wire [7:0] rx_byte    = {shift_reg[6:0], bus.sda};
    wire       addr_hit   = rx_byte[7:1] == `ACC_SLAVE_ADDR;
    wire       dir_read   = rx_byte[0] == `ACC_DIR_READ;
    wire [AW-1:0] ptr_idx = ptr_reg[AW-1:0];
    wire [7:0] ptr_inc    = ptr_reg + `ACC_BYTE_ONE;
    wire       in_byte    = bit_reg < `ACC_ACK_BIT;
    wire       at_last    = bit_reg == `ACC_LAST_BIT;
    wire       master_nak = bus.sda;

    always_comb begin
        state_next   = state_reg;
        go_next      = go_reg;
        bit_next     = bit_reg;
        shift_next   = shift_reg;
        tx_next      = tx_reg;
        ptr_next     = ptr_reg;
        ack_next     = ack_reg;
        seen_next    = seen_reg;
        evt_tog_next = evt_tog_reg;
        mem_we       = 1'b0;
        if (start_pend) begin
            // a repeated start lands here as well and restarts addressing
            seen_next  = start_tog_reg;
            state_next = DEV_ADDR;
            bit_next   = `ACC_FIRST_BIT;
            shift_next = {7'h00, bus.sda};
            ack_next   = 1'b0;
        end else if (state_reg != DEV_IDLE) begin
            if (in_byte && !at_last) begin
                bit_next   = bit_reg + `ACC_FIRST_BIT;
                shift_next = rx_byte;
            end else if (at_last) begin
                bit_next = `ACC_ACK_BIT;
                ack_next = 1'b1;
                unique case (state_reg)
                    DEV_ADDR: begin
                        ack_next = addr_hit;
                        go_next  = !addr_hit ? DEV_IDLE : (dir_read ? DEV_RD : DEV_REG);
                    end
                    DEV_REG: begin
                        ptr_next = rx_byte;
                        go_next  = DEV_WR;
                    end
                    DEV_WR: begin
                        mem_we          = 1'b1;
                        ptr_next        = ptr_inc;
                        evt_tog_next[0] = ~evt_tog_reg[0];
                        go_next         = DEV_WR;
                    end
                    DEV_RD: begin
                        ack_next        = 1'b0;
                        ptr_next        = ptr_inc;
                        evt_tog_next[1] = ~evt_tog_reg[1];
                        go_next         = DEV_RD;
                    end
                    DEV_IDLE: begin
                        go_next = DEV_IDLE;
                    end
                endcase
            end else begin
                bit_next   = `ACC_BIT_ZERO;
                state_next = (state_reg == DEV_RD && master_nak) ? DEV_IDLE : go_reg;
                tx_next    = mem[ptr_idx];
            end
        end
    end

    always_ff @(posedge bus.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg   <= DEV_IDLE;
            go_reg      <= DEV_IDLE;
            bit_reg     <= `ACC_BIT_ZERO;
            shift_reg   <= `ACC_BYTE_ZERO;
            tx_reg      <= `ACC_BYTE_ZERO;
            ptr_reg     <= `ACC_BYTE_ZERO;
            ack_reg     <= 1'b0;
            seen_reg    <= 1'b0;
            evt_tog_reg <= 2'h0;
        end else begin
            state_reg   <= state_next;
            go_reg      <= go_next;
            bit_reg     <= bit_next;
            shift_reg   <= shift_next;
            tx_reg      <= tx_next;
            ptr_reg     <= ptr_next;
            ack_reg     <= ack_next;
            seen_reg    <= seen_next;
            evt_tog_reg <= evt_tog_next;
        end
    end

    // register contents and the event details handed to the system side;
    // held until the next byte, which is at least nine bus clocks away
    always_ff @(posedge bus.scl) begin
        if (mem_we) begin
            mem[ptr_idx] <= rx_byte;
            wr_addr_reg  <= ptr_reg;
            wr_data_reg  <= rx_byte;
        end
        if (state_reg == DEV_RD && at_last) begin
            rd_addr_reg <= ptr_reg;
        end
    end

    // ---------------------------------------------------------------
    // data line drive on the falling clock
    // ---------------------------------------------------------------
    wire drive_data = (state_reg == DEV_RD) && in_byte && !tx_reg[~bit_reg[2:0]];
    wire drive_ack  = (bit_reg == `ACC_ACK_BIT) && ack_reg;

    always_ff @(negedge bus.scl or negedge resetn_in) begin
        if (!resetn_in) begin
            sda_low_reg <= 1'b0;
        end else begin
            sda_low_reg <= drive_data || drive_ack;
        end
    end

    // open drain only; the clock line is never pulled, so no stretching
    assign bus.dev_sda_oe = sda_low_reg;
    assign bus.dev_scl_oe = 1'b0;

    // ---------------------------------------------------------------
    // crossing to the system clock
    // ---------------------------------------------------------------
    // the address select pin is disabled on this variant and never read
    logic [2:0] evt_s1_reg;
    logic [2:0] evt_s2_reg;
    logic [1:0] evt_s3_reg;

    wire       sel_lvl  = state_reg != DEV_IDLE && state_reg != DEV_ADDR;
    wire [1:0] evt_edge = evt_s2_reg[1:0] ^ evt_s3_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            evt_s1_reg <= 3'h0;
            evt_s2_reg <= 3'h0;
            evt_s3_reg <= 2'h0;
        end else begin
            evt_s1_reg <= {sel_lvl, evt_tog_reg};
            evt_s2_reg <= evt_s1_reg;
            evt_s3_reg <= evt_s2_reg[1:0];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_stb_out   <= 1'b0;
            wr_addr_out  <= `ACC_BYTE_ZERO;
            wr_data_out  <= `ACC_BYTE_ZERO;
            rd_stb_out   <= 1'b0;
            rd_addr_out  <= `ACC_BYTE_ZERO;
            selected_out <= 1'b0;
        end else begin
            wr_stb_out   <= evt_edge[0];
            rd_stb_out   <= evt_edge[1];
            selected_out <= evt_s2_reg[2];
            if (evt_edge[0]) begin
                wr_addr_out <= wr_addr_reg;
                wr_data_out <= wr_data_reg;
            end
            if (evt_edge[1]) begin
                rd_addr_out <= rd_addr_reg;
            end
        end
    end

endmodule : acc_i2c_dev

// ### rtl/acc_i2c_host.sv
// master end: generates the bus clock and runs register reads and writes
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_i2c_host #(
    parameter int QTR_CYC = `ACC_QTR_CYC(`ACC_FAST_BPS)
) (
    acc_i2c_if.host          bus,
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_read_in,
    input  wire logic [7:0]  cmd_reg_in,
    input  wire logic [7:0]  cmd_len_in,
    output logic             cmd_ready_out,
    input  wire logic [7:0]  wr_data_in,
    output logic             wr_take_out,
    output logic [7:0]       rd_data_out,
    output logic             rd_valid_out,
    output logic             nak_out,
    output logic             done_out
);
    import acc_pkg::*;

    // ---------------------------------------------------------------
    // quarter-bit tick and data line synchroniser
    // ---------------------------------------------------------------
    logic [7:0] div_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;

    wire tick = div_reg == 8'(QTR_CYC - 1);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_reg    <= 8'h00;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            div_reg    <= tick ? 8'h00 : div_reg + 8'h01;
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // transfer sequencer
    // ---------------------------------------------------------------
    acc_hst_state_type st_reg, st_next;
    acc_hst_seg_type   seg_reg, seg_next;
    logic [1:0] q_reg, q_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next, cnt_reg, cnt_next, reg_reg, reg_next;
    logic       rd_reg, rd_next, rep_reg, rep_next, scl_reg, scl_next, sda_reg, sda_next;
    logic       take, got, nak, fin;

    wire tx_seg  = seg_reg != SEG_RD;
    wire last    = cnt_reg == `ACC_BYTE_ONE;
    wire bit_val = tx_seg ? (bit_reg == `ACC_ACK_BIT || sh_reg[7])
                          : (bit_reg != `ACC_ACK_BIT || last);
    wire [7:0] cnt_dec = cnt_reg - `ACC_BYTE_ONE;

    assign cmd_ready_out = st_reg == HST_IDLE;

    always_comb begin
        st_next = st_reg; seg_next = seg_reg; q_next = q_reg; bit_next = bit_reg;
        sh_next = sh_reg; cnt_next = cnt_reg; reg_next = reg_reg; rd_next = rd_reg;
        rep_next = rep_reg; scl_next = scl_reg; sda_next = sda_reg;
        take = 1'b0; got = 1'b0; nak = 1'b0; fin = 1'b0;
        if (st_reg == HST_IDLE) begin
            if (cmd_valid_in) begin
                st_next  = HST_START; seg_next = SEG_ADW; q_next = 2'h0; rep_next = 1'b0;
                sh_next  = {`ACC_SLAVE_ADDR, `ACC_DIR_WRITE};
                reg_next = cmd_reg_in; rd_next = cmd_read_in;
                cnt_next = (cmd_read_in && cmd_len_in == `ACC_BYTE_ZERO) ? `ACC_BYTE_ONE : cmd_len_in;
            end
        end else if (tick) begin
            q_next = q_reg + 2'h1;
            unique case (st_reg)
                HST_START: begin
                    unique case (q_reg)
                        2'h0: scl_next = !rep_reg;
                        2'h1: sda_next = 1'b1;
                        2'h2: scl_next = 1'b1;
                        2'h3: begin sda_next = 1'b0; st_next = HST_BIT; bit_next = `ACC_BIT_ZERO; end
                    endcase
                end
                HST_STOP: begin
                    unique case (q_reg)
                        2'h0: scl_next = 1'b0;
                        2'h1: sda_next = 1'b0;
                        2'h2: scl_next = 1'b1;
                        2'h3: begin sda_next = 1'b1; st_next = HST_IDLE; fin = 1'b1; end
                    endcase
                end
                HST_BIT: begin
                    unique case (q_reg)
                        2'h0: scl_next = 1'b0;
                        2'h1: sda_next = bit_val;
                        2'h2: scl_next = 1'b1;
                        2'h3: begin
                            if (bit_reg != `ACC_ACK_BIT) begin
                                sh_next  = {sh_reg[6:0], sda_s2_reg};
                                bit_next = bit_reg + `ACC_FIRST_BIT;
                            end else begin
                                bit_next = `ACC_BIT_ZERO;
                                if (tx_seg && sda_s2_reg) begin
                                    nak = 1'b1; st_next = HST_STOP;
                                end else begin
                                    unique case (seg_reg)
                                        SEG_ADW: begin seg_next = SEG_REG; sh_next = reg_reg; end
                                        SEG_REG: begin
                                            if (rd_reg) begin
                                                st_next = HST_START; rep_next = 1'b1; seg_next = SEG_ADR;
                                                sh_next = {`ACC_SLAVE_ADDR, `ACC_DIR_READ};
                                            end else if (cnt_reg == `ACC_BYTE_ZERO) begin
                                                st_next = HST_STOP;
                                            end else begin
                                                seg_next = SEG_WR; sh_next = wr_data_in; take = 1'b1;
                                            end
                                        end
                                        SEG_ADR: seg_next = SEG_RD;
                                        SEG_WR, SEG_RD: begin
                                            got = seg_reg == SEG_RD;
                                            cnt_next = cnt_dec;
                                            if (last) begin
                                                st_next = HST_STOP;
                                            end else if (seg_reg == SEG_WR) begin
                                                sh_next = wr_data_in; take = 1'b1;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                default: st_next = HST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= HST_IDLE; seg_reg <= SEG_ADW; q_reg <= 2'h0; bit_reg <= `ACC_BIT_ZERO;
            sh_reg <= `ACC_BYTE_ZERO; cnt_reg <= `ACC_BYTE_ZERO; reg_reg <= `ACC_BYTE_ZERO;
            rd_reg <= 1'b0; rep_reg <= 1'b0; scl_reg <= 1'b1; sda_reg <= 1'b1;
            wr_take_out <= 1'b0; rd_valid_out <= 1'b0; nak_out <= 1'b0; done_out <= 1'b0;
            rd_data_out <= `ACC_BYTE_ZERO;
        end else begin
            st_reg <= st_next; seg_reg <= seg_next; q_reg <= q_next; bit_reg <= bit_next;
            sh_reg <= sh_next; cnt_reg <= cnt_next; reg_reg <= reg_next;
            rd_reg <= rd_next; rep_reg <= rep_next; scl_reg <= scl_next; sda_reg <= sda_next;
            wr_take_out <= take; rd_valid_out <= got; nak_out <= nak; done_out <= fin;
            if (got) begin
                rd_data_out <= sh_reg;
            end
        end
    end

    // open drain: a high level is only ever a release
    assign bus.host_scl_oe = ~scl_reg;
    assign bus.host_sda_oe = ~sda_reg;

endmodule : acc_i2c_host

// ### dv/acc_i2c_checker.sv
// checker for the two-wire link between the host and accelerometer ends
`timescale 1ns/1ps

module acc_i2c_checker #(
    parameter int QTR_CYC = 2
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    // -------------------------
    // bus decode
    // -------------------------
    logic       scl_q, sda_q, first, mine, rd, ackd;
    logic [3:0] bit_cnt;
    logic [7:0] sh, low_cnt;
    wire        rise  = scl & ~scl_q;
    wire        start = scl & scl_q & sda_q & ~sda;
    wire        ack   = rise & (bit_cnt == 4'h8);
    // a rise after a refused ack belongs to a stop or restart, not to data
    wire        data  = rise & (bit_cnt < 4'h8) & (bit_cnt != 4'h0 | ackd);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {scl_q, sda_q, first, mine, rd, ackd} <= 6'h30;
            bit_cnt <= 4'h0;
            sh      <= 8'h00;
            low_cnt <= 8'h00;
        end else begin
            scl_q   <= scl;
            sda_q   <= sda;
            low_cnt <= (scl & ~sda) ? low_cnt + 8'h01 : 8'h00;
            if (start) begin
                bit_cnt <= 4'h0;
                first   <= 1'b1;
                ackd    <= 1'b1;
            end else if (rise) begin
                bit_cnt <= ack ? 4'h0 : bit_cnt + 4'h1;
                sh      <= ack ? sh : {sh[6:0], sda};
                ackd    <= ack ? ~sda : ackd;
                first   <= ack ? 1'b0 : first;
                mine    <= (ack & first) ? (sh[7:1] == 7'h1d) : mine;
                rd      <= (ack & first) ? sh[0] : rd;
            end
        end
    end

    // -------------------------
    // properties
    // -------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    a_dev_no_stretch: assert property (!dev_scl_oe)
        else $error("device pulled scl");
    a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device moved sda with scl high");
    a_addr_ack: assert property (ack & first |-> dev_sda_oe == (sh[7:1] == 7'h1d))
        else $error("address ack wrong");
    a_write_ack: assert property (ack & !first & mine & !rd |-> dev_sda_oe)
        else $error("write byte not acked");
    a_read_ack_free: assert property (ack & !first & mine & rd |-> !dev_sda_oe)
        else $error("device held read ack");
    a_read_host_quiet: assert property (data & !first & mine & rd |-> !host_sda_oe)
        else $error("host drove read data");
    a_write_dev_quiet: assert property (data & (first | !rd) |-> !dev_sda_oe)
        else $error("device drove host data");
    a_lines_idle_high: assert property (low_cnt <= 8'(2 * QTR_CYC + 1))
        else $error("sda held low too long");

    c_write_ack: cover property (ack & !first & mine & !rd & dev_sda_oe);
    c_read_nak: cover property (ack & !first & mine & rd & sda);
    c_restart: cover property (start & mine);
endmodule : acc_i2c_checker

// ### dv/acc_i2c_tb_top.sv
// self-checking bench: host end runs register reads and writes on the accelerometer end
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin miscompares++; \
    $display("ERROR %s exp %h got %h", nm, ex, gt); end end

module acc_i2c_tb_top;
    // fast mode: 25 MHz over 4 * 16 keeps the bus just under 400 kbit/s
    localparam int Q = 16;
    logic        clk_in, resetn_in, slave_address_select_pin_in;
    logic        cmd_valid_in, cmd_read_in, cmd_ready_out, wr_take_out, rd_valid_out;
    logic [7:0]  cmd_reg_in, cmd_len_in, wr_data_in, rd_data_out, wr_addr_out, wr_data_out, rd_addr_out;
    logic        nak_out, done_out, wr_stb_out, rd_stb_out, selected_out;
    logic [7:0]  wbuf[8], rq[$], rs[$];
    logic [15:0] ws[$];
    int          wi, naks, miscompares, checks_done, sel_hits;

    acc_i2c_if bus_if ();
    acc_i2c_host #(.QTR_CYC(Q)) acc_i2c_host_i (.bus(bus_if.host), .clk_in, .resetn_in, .cmd_valid_in,
        .cmd_read_in, .cmd_reg_in, .cmd_len_in, .cmd_ready_out, .wr_data_in, .wr_take_out, .rd_data_out,
        .rd_valid_out, .nak_out, .done_out);
    acc_i2c_dev acc_i2c_dev_i (.bus(bus_if.dev), .clk_in, .resetn_in, .slave_address_select_pin_in,
        .wr_stb_out, .wr_addr_out, .wr_data_out, .rd_stb_out, .rd_addr_out, .selected_out);
    acc_i2c_checker #(.QTR_CYC(Q)) acc_i2c_checker_i (.clk_in, .resetn_in, .host_scl_oe(bus_if.host_scl_oe),
        .host_sda_oe(bus_if.host_sda_oe), .dev_scl_oe(bus_if.dev_scl_oe), .dev_sda_oe(bus_if.dev_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // -------------------------
    // monitor and write-data feed
    // -------------------------
    always @(posedge clk_in) begin
        if (rd_valid_out === 1'b1) rq.push_back(rd_data_out);
        if (wr_stb_out === 1'b1) ws.push_back({wr_addr_out, wr_data_out});
        if (rd_stb_out === 1'b1) rs.push_back(rd_addr_out);
        if (nak_out === 1'b1) naks++;
        if (selected_out === 1'b1) sel_hits++;
        if (wr_take_out === 1'b1) wi = wi + 1;
        // the host samples a byte a cycle before its take pulse, so keep the next one ready
        wr_data_in <= wbuf[wi[2:0]];
    end

    task automatic xfer(input logic rd, input logic [7:0] rg, input logic [7:0] n);
        int t;
        rq.delete();
        ws.delete();
        rs.delete();
        wi = 0;
        sel_hits = 0;
        cmd_valid_in <= 1'b1;
        cmd_read_in  <= rd;
        cmd_reg_in   <= rg;
        cmd_len_in   <= n;
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        t = 0;
        while (done_out !== 1'b1 && t < 8000) begin
            @(posedge clk_in);
            t++;
            if (t == 1) `CHK("busy", 1'b0, cmd_ready_out)
        end
        `CHK("done", 1'b1, done_out)
        `CHK("ready", 1'b1, cmd_ready_out)
        `CHK("selected", 1'b1, sel_hits > 0)
        if (rd) `CHK("released", 1'b0, selected_out)
        @(posedge clk_in);
    endtask : xfer

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // -------------------------
    // tests
    // -------------------------
    initial begin
        {miscompares, checks_done, naks, wi} = '0;
        {resetn_in, cmd_valid_in, cmd_read_in, slave_address_select_pin_in} = 4'h0;
        {cmd_reg_in, cmd_len_in} = '0;
        wbuf = '{8'h05, 8'ha5, 8'h5a, 8'hc3, 8'h00, 8'hff, 8'h3c, 8'h96};
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        xfer(1'b0, 8'h16, 8'h01);
        `CHK("wr single", 16'h1605, ws[0])
        xfer(1'b1, 8'h16, 8'h01);
        `CHK("rd single", 8'h05, rq[0])
        `CHK("rd single addr", 8'h16, rs[0])
        $display("test single byte done");
        xfer(1'b0, 8'h1e, 8'h03);
        `CHK("wr multi count", 3, ws.size())
        for (int i = 0; i < 3; i++) begin
            `CHK("wr multi", {8'h1e + 8'(i), wbuf[i]}, ws[i])
        end
        xfer(1'b1, 8'h1e, 8'h03);
        for (int i = 0; i < 3; i++) begin
            `CHK("rd multi", wbuf[i], rq[i])
            `CHK("rd multi addr", 8'h1e + 8'(i), rs[i])
        end
        $display("test multi byte done");
        // the address select pin is dead on this part, so toggling it must change nothing
        slave_address_select_pin_in <= 1'b1;
        xfer(1'b0, 8'h1f, 8'h00);
        `CHK("pointer only", 0, ws.size())
        xfer(1'b1, 8'h1f, 8'h00);
        `CHK("rd len zero", 1, rq.size())
        `CHK("pin ignored", wbuf[1], rq[0])
        `CHK("no nak", 0, naks)
        $display("test pointer and pin done");
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        miscompares++;
        $display("ERROR watchdog exp done got hang");
        close_out();
    end
endmodule : acc_i2c_tb_top
